// ### job_model.sv
// Behavioural model of the outside logic that carries out jobs.
`timescale 1ns/100ps
`default_nettype none
module job_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic job_req,
  input wire logic [7:0] res_sel,
  input wire logic slow,
  output logic job_done,
  output logic [7:0] job_result,
  output logic [63:0] job_data
);
  int wait_reg;
  // Answers after a short or long wait; idle result lines toggle so a late sample shows.
  always_ff @(posedge clk) begin
    job_done <= 1'b0;
    job_result <= ~job_result;
    job_data <= ~job_data;
    if (sys_rst) begin
      wait_reg <= 0;
      job_result <= 8'h00;
      job_data <= 64'h0;
    end else if (job_req) begin
      wait_reg <= slow ? 20 : 2;
    end else if (wait_reg == 1) begin
      job_done <= 1'b1;
      job_result <= res_sel;
      job_data <= 64'h0123456789ABCDEF;
      wait_reg <= 0;
    end else if (wait_reg > 1) begin
      wait_reg <= wait_reg - 1;
    end
  end
endmodule
`default_nettype wire

// ### remote_cmd_pkg.sv
// Shared constants for the remote command and status unit.
`default_nettype none
package remote_cmd_pkg;
  // Clock rate and derived timing.
  localparam int CLK_MHZ = 100;
  localparam int LAMP_HALF_MS = 250;
  localparam int LAMP_HALF_CYC = LAMP_HALF_MS * 1000 * CLK_MHZ;
  localparam int LAMP_FLASHES = 3;
  localparam int SETTLE_MS = 50;
  localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;

  // Command codes handed over by the line parser.
  localparam logic [3:0] CMD_STATUS = 4'h0;
  localparam logic [3:0] CMD_CONFIG = 4'h1;
  localparam logic [3:0] CMD_SET_ID = 4'h2;
  localparam logic [3:0] CMD_LAMP = 4'h3;
  localparam logic [3:0] CMD_RESTORE = 4'h4;
  localparam logic [3:0] CMD_AUTO = 4'h5;
  localparam logic [3:0] CMD_SAVE = 4'h6;
  localparam logic [3:0] CMD_BIAS = 4'h7;
  localparam logic [3:0] CMD_CHANNEL = 4'h8;

  // Result codes, two's complement; zero means OK.
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_NO_OPTION = 8'hFF;
  localparam logic [7:0] RES_BAD_CHAN = 8'hFE;
  localparam logic [7:0] RES_BAD_CMD = 8'hFD;
  localparam logic [7:0] RES_BAD_UNIT = 8'hFC;
  localparam logic [7:0] RES_FUNC_FAIL = 8'hFB;
  localparam logic [7:0] RES_BAD_PARAM = 8'hFA;
  localparam logic [7:0] RES_BR_ILLEGAL = 8'hF5;
  localparam logic [7:0] RES_BR_ITER = 8'hF4;
  localparam logic [7:0] RES_CC_BAD_RDG = 8'hF3;
  localparam logic [7:0] RES_CC_ITER = 8'hF2;
  localparam logic [7:0] RES_NO_BALANCE = 8'hF1;
  localparam logic [7:0] RES_NO_ZERO = 8'hF0;
  localparam logic [7:0] RES_IEXC_MODE = 8'hEF;
  localparam logic [7:0] RES_VEXC_MODE = 8'hEE;
  localparam logic [7:0] RES_MEM_MODE = 8'hED;
  localparam logic [7:0] RES_MEM_SEARCH = 8'hEC;
  localparam logic [7:0] RES_MEM_SIZE = 8'hEB;
  localparam logic [7:0] RES_MEM_CS = 8'hEA;

  // Unit identifier.
  localparam logic [7:0] UNIT_ID_RST = 8'h01;
  localparam logic [7:0] UNIT_ID_MAX = 8'h63;

  // Status map bit positions.
  localparam int UBIT_SETTINGS = 0;
  localparam int UBIT_OPTIONS = 1;
  localparam int UBIT_CAL = 2;
  localparam int CBIT_SHORT = 0;
  localparam int CBIT_OPEN = 1;
  localparam int CBIT_OVLD = 2;

  // Second miscellaneous option byte bit positions.
  localparam int CONVERTER_FITTED_BIT = 1;
  localparam int IGNORE_PWR_BTN_BIT = 7;

  // Auto-scale settings.
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_ON = 2'h1;
  localparam logic [1:0] AUTO_NOW = 2'h2;

  // Factory defaults, fixed point in tenths.
  localparam logic [15:0] DFLT_GAIN_X10 = 16'h000A;
  localparam logic [15:0] DFLT_SENS_X10 = 16'h0064;
  localparam logic [15:0] DFLT_FSCI_X10 = 16'h2710;
  localparam logic [15:0] DFLT_FSCO_X10 = 16'h0064;
  localparam logic [15:0] DFLT_IEXC_X10 = 16'h0028;
  localparam logic [1:0] MODE_CONST_CURRENT = 2'h0;
endpackage
`default_nettype wire

// ### remote_cmd_sva.sv
// Port checker for the remote command and status unit.
`timescale 1ns/100ps
`default_nettype none
module remote_cmd_sva
  import remote_cmd_pkg::*;
#(
  parameter int NUM_CHANS = 4,
  parameter int LAMP_HALF = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [3:0] rsp_cmd,
  input wire logic [7:0] rsp_result,
  input wire logic [63:0] rsp_data,
  input wire logic [2:0] load_fail,
  input wire logic lamp_all,
  input wire logic job_req,
  input wire logic [3:0] job_cmd,
  input wire logic job_done,
  input wire logic [7:0] job_result,
  input wire logic [15:0] dflt_gain_x10,
  input wire logic [15:0] dflt_fsci_x10,
  input wire logic [15:0] dflt_iexc_x10,
  input wire logic dflt_ac_coupling,
  input wire logic [1:0] auto_mode,
  input wire logic [3*NUM_CHANS-1:0] chan_gain_step
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Status answers carry the load flags seen at the taking edge.
  a_unit_map: assert property (rsp_valid && rsp_cmd == CMD_STATUS && rsp_result == RES_OK
    |-> rsp_data[7:0] == {5'h00, $past(load_fail)}) else $error("unit map wrong");
  a_err_nodata: assert property (rsp_valid && rsp_result != RES_OK
    |-> rsp_data == 64'h0) else $error("error answer carries data");
  // A job request stalls the port for at least one cycle.
  a_job_pulse: assert property (job_req |-> !cmd_ready ##1 !job_req)
    else $error("job request not a stalled pulse");
  a_job_answer: assert property (job_done && !cmd_ready |=> rsp_valid && cmd_ready)
    else $error("job completion not answered");
  a_func_fail: assert property (rsp_valid && $past(job_done)
    && (rsp_cmd == CMD_SAVE || rsp_cmd == CMD_RESTORE)
    |-> rsp_result == ($past(job_result) == RES_OK ? RES_OK : RES_FUNC_FAIL))
    else $error("function result not mapped");
  a_restore_dflt: assert property (job_req && job_cmd == CMD_RESTORE
    |-> dflt_gain_x10 == DFLT_GAIN_X10 && dflt_fsci_x10 == DFLT_FSCI_X10
    && dflt_iexc_x10 == DFLT_IEXC_X10 && dflt_ac_coupling)
    else $error("defaults not loaded");
  // Each lit phase of the lamp test lasts exactly one half period.
  a_lamp_half: assert property ($fell(lamp_all)
    |-> $past(lamp_all, LAMP_HALF) && !$past(lamp_all, LAMP_HALF + 1))
    else $error("lamp phase length wrong");
  a_auto_fill: assert property (auto_mode == AUTO_NOW && $past(auto_mode) != AUTO_NOW
    |-> chan_gain_step == {NUM_CHANS{3'h7}}) else $error("gains not at top");
  a_gain_down: assert property (auto_mode == AUTO_NOW && $past(auto_mode) == AUTO_NOW
    |-> chan_gain_step <= $past(chan_gain_step)) else $error("gain rose in one-shot");

  c_status: cover property (rsp_valid && rsp_cmd == CMD_STATUS);
  c_lamp: cover property ($rose(lamp_all));
  c_restore: cover property (job_req && job_cmd == CMD_RESTORE);
  c_auto: cover property (auto_mode == AUTO_NOW);
endmodule
bind remote_command_status_unit remote_cmd_sva #(
  .NUM_CHANS(NUM_CHANS),
  .LAMP_HALF(LAMP_HALF)
) u_sva (.clk, .sys_rst, .cmd_ready, .rsp_valid, .rsp_cmd, .rsp_result, .rsp_data,
  .load_fail, .lamp_all, .job_req, .job_cmd, .job_done, .job_result, .dflt_gain_x10,
  .dflt_fsci_x10, .dflt_iexc_x10, .dflt_ac_coupling, .auto_mode, .chan_gain_step);
`default_nettype wire

// ### remote_command_status_unit.sv
// Remote command interpreter: status, config, identifier and function commands.
`timescale 1ns/100ps
`default_nettype none
module remote_command_status_unit
  import remote_cmd_pkg::*;
#(
  parameter int NUM_CHANS = 4,
  parameter int START_CHAN = 1,
  parameter int GAIN_STEPS = 8,
  parameter int LAMP_HALF = LAMP_HALF_CYC,
  parameter int SETTLE = SETTLE_CYC,
  parameter logic [15:0] SERIAL_NUM = 16'h0000,
  parameter logic [7:0] FILTER_KHZ = 8'h00,
  parameter logic [7:0] MISC_OPTS = 8'h00,
  parameter logic HAS_AUTO_GAIN = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_unit,
  input wire logic [7:0] cmd_chan,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_query,
  input wire logic [15:0] cmd_param,
  output logic rsp_valid,
  output logic [7:0] rsp_unit,
  output logic [3:0] rsp_cmd,
  output logic [7:0] rsp_result,
  output logic [63:0] rsp_data,
  input wire logic [2:0] load_fail,
  input wire logic [NUM_CHANS-1:0] short_pin,
  input wire logic [NUM_CHANS-1:0] open_pin,
  input wire logic [NUM_CHANS-1:0] ovld_pin,
  input wire logic converter_fitted_flag,
  input wire logic ignore_power_button_flag,
  output logic lamp_all,
  output logic job_req,
  output logic [3:0] job_cmd,
  output logic [7:0] job_chan,
  output logic [15:0] job_param,
  input wire logic job_done,
  input wire logic [7:0] job_result,
  input wire logic [63:0] job_data,
  output logic [15:0] dflt_gain_x10,
  output logic [15:0] dflt_sens_x10,
  output logic [15:0] dflt_fsci_x10,
  output logic [15:0] dflt_fsco_x10,
  output logic [15:0] dflt_iexc_x10,
  output logic [1:0] dflt_input_mode,
  output logic dflt_ac_coupling,
  output logic [1:0] auto_mode,
  output logic [3*NUM_CHANS-1:0] chan_gain_step
);
  localparam int GW = $clog2(GAIN_STEPS);
  localparam logic [GW-1:0] GAIN_TOP = GW'(GAIN_STEPS - 1);

  typedef enum logic [0:0] {ST_IDLE, ST_JOB} state_t;

  state_t state_reg;
  logic [7:0] unit_id_reg;
  logic [NUM_CHANS-1:0] short_s1, short_s2, open_s1, open_s2, ovld_s1, ovld_s2;
  logic [NUM_CHANS-1:0] ovld_seen_reg;
  logic [31:0] lamp_cnt_reg;
  logic [2:0] lamp_phase_reg;
  logic [31:0] settle_cnt_reg;
  logic [GW-1:0] gain_reg [NUM_CHANS];
  logic [63:0] status_word;

  // Fault pins come from the analogue front end, so sync them first.
  always_ff @(posedge clk) begin
    short_s1 <= short_pin;
    short_s2 <= short_s1;
    open_s1 <= open_pin;
    open_s2 <= open_s1;
    ovld_s1 <= ovld_pin;
    ovld_s2 <= ovld_s1;
  end

  // Command decode; a foreign unit number leaves the request unanswered.
  wire unit_hit = cmd_unit == unit_id_reg;
  wire take = cmd_valid && cmd_ready && unit_hit;
  wire is_status = cmd_code == CMD_STATUS;
  wire is_config = cmd_code == CMD_CONFIG;
  wire is_set_id = cmd_code == CMD_SET_ID;
  wire is_lamp = cmd_code == CMD_LAMP;
  wire is_restore = cmd_code == CMD_RESTORE;
  wire is_auto = cmd_code == CMD_AUTO;
  wire is_save = cmd_code == CMD_SAVE;
  wire is_bias = cmd_code == CMD_BIAS;
  wire is_chan = cmd_code == CMD_CHANNEL;
  wire is_known = cmd_code <= CMD_CHANNEL;
  wire is_global = is_status || is_bias || is_config;
  wire is_read_only = is_status || is_config || is_bias;
  wire is_action = is_lamp || is_restore || is_save;
  wire chan_bad = cmd_chan > 8'(NUM_CHANS);
  wire id_bad = cmd_param == 16'h0000 || cmd_param > {8'h00, UNIT_ID_MAX};
  wire auto_bad = cmd_param > {14'h0000, AUTO_NOW};

  // Check order: command, channel, form, option, then parameter range.
  wire [7:0] pre_res =
    !is_known ? RES_BAD_CMD :
    (chan_bad && !is_global) ? RES_BAD_CHAN :
    (is_read_only && !cmd_query) ? RES_FUNC_FAIL :
    (is_action && cmd_query) ? RES_BAD_CMD :
    (is_auto && !HAS_AUTO_GAIN) ? RES_NO_OPTION :
    (is_auto && !cmd_query && auto_bad) ? RES_BAD_PARAM :
    (is_set_id && !cmd_query && id_bad) ? RES_BAD_UNIT :
    RES_OK;
  wire good = pre_res == RES_OK;
  wire needs_job = good && (is_restore || is_save || is_bias || is_chan);
  wire set_id_now = take && good && is_set_id && !cmd_query;
  wire set_auto = take && good && is_auto && !cmd_query;
  wire start_lamp = take && good && is_lamp;
  wire start_restore = take && good && is_restore;

  // Status word: unit map in the low byte, one byte per channel above it.
  always_comb begin
    status_word = 64'h0;
    status_word[2:0] = load_fail;
    for (int i = 0; i < NUM_CHANS; i++) begin
      status_word[8*i+8+CBIT_SHORT] = ~short_s2[i];
      status_word[8*i+8+CBIT_OPEN] = ~open_s2[i];
      status_word[8*i+8+CBIT_OVLD] = ~ovld_s2[i];
    end
  end

  // Second option byte carries the converter and power button flags.
  wire [7:0] misc2 = (8'(converter_fitted_flag) << CONVERTER_FITTED_BIT) |
    (8'(ignore_power_button_flag) << IGNORE_PWR_BTN_BIT);
  wire [63:0] config_word = {SERIAL_NUM, FILTER_KHZ, unit_id_reg, 8'(NUM_CHANS),
    8'(START_CHAN), MISC_OPTS, misc2};

  // Immediate answer data for commands handled inside this block.
  wire [63:0] local_data =
    is_status ? status_word :
    is_config ? config_word :
    is_set_id ? {56'h0, unit_id_reg} :
    is_auto ? {62'h0, auto_mode} :
    64'h0;

  // Only channel jobs may report their own family of codes; any other non-OK result is a failure.
  wire [7:0] jr = job_result;
  wire res_nulling = $signed(jr) <= $signed(RES_BR_ILLEGAL) &&
    $signed(jr) >= $signed(RES_CC_ITER);
  wire res_mode = $signed(jr) <= $signed(RES_NO_BALANCE) &&
    $signed(jr) >= $signed(RES_VEXC_MODE);
  wire res_mem = $signed(jr) <= $signed(RES_MEM_MODE) &&
    $signed(jr) >= $signed(RES_MEM_CS);
  wire res_plain = jr == RES_OK || jr == RES_NO_OPTION || jr == RES_BAD_CHAN ||
    jr == RES_FUNC_FAIL || jr == RES_BAD_PARAM;
  wire chan_job = job_cmd == CMD_CHANNEL;
  wire [7:0] job_res_final =
    jr == RES_OK ? RES_OK :
    (chan_job && (res_plain || res_nulling || res_mode || res_mem)) ? jr :
    RES_FUNC_FAIL;

  // Handshake with the host: one command in flight at a time.
  assign cmd_ready = state_reg == ST_IDLE;

  // Sequencer and answer registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      unit_id_reg <= UNIT_ID_RST;
      rsp_valid <= 1'b0;
      rsp_unit <= 8'h00;
      rsp_cmd <= 4'h0;
      rsp_result <= RES_OK;
      rsp_data <= 64'h0;
      job_req <= 1'b0;
      job_cmd <= 4'h0;
      job_chan <= 8'h00;
      job_param <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      job_req <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (take && needs_job) begin
            job_req <= 1'b1;
            job_cmd <= cmd_code;
            job_chan <= cmd_chan;
            job_param <= cmd_param;
            state_reg <= ST_JOB;
          end else if (take) begin
            rsp_valid <= 1'b1;
            rsp_unit <= set_id_now ? cmd_param[7:0] : unit_id_reg;
            rsp_cmd <= cmd_code;
            rsp_result <= pre_res;
            rsp_data <= good ? local_data : 64'h0;
          end
          if (set_id_now) begin
            unit_id_reg <= cmd_param[7:0];
          end
        end
        ST_JOB: begin
          if (job_done) begin
            rsp_valid <= 1'b1;
            rsp_unit <= unit_id_reg;
            rsp_cmd <= job_cmd;
            rsp_result <= job_res_final;
            rsp_data <= jr == RES_OK ? job_data : 64'h0;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Defaults are snapped when a restore starts; the channel logic loads them on job_req.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dflt_gain_x10 <= 16'h0000;
      dflt_sens_x10 <= 16'h0000;
      dflt_fsci_x10 <= 16'h0000;
      dflt_fsco_x10 <= 16'h0000;
      dflt_iexc_x10 <= 16'h0000;
      dflt_input_mode <= MODE_CONST_CURRENT;
      dflt_ac_coupling <= 1'b0;
    end else if (start_restore) begin
      dflt_gain_x10 <= DFLT_GAIN_X10;
      dflt_sens_x10 <= DFLT_SENS_X10;
      dflt_fsci_x10 <= DFLT_FSCI_X10;
      dflt_fsco_x10 <= DFLT_FSCO_X10;
      dflt_iexc_x10 <= DFLT_IEXC_X10;
      dflt_input_mode <= MODE_CONST_CURRENT;
      dflt_ac_coupling <= 1'b1;
    end
  end

  // Lamp test: six half periods, lit on the even ones, so three flashes.
  wire lamp_half_tick = lamp_cnt_reg == 32'(LAMP_HALF - 1);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lamp_cnt_reg <= 32'h0;
      lamp_phase_reg <= 3'h0;
      lamp_all <= 1'b0;
    end else if (start_lamp) begin
      lamp_cnt_reg <= 32'h0;
      lamp_phase_reg <= 3'(2 * LAMP_FLASHES);
      lamp_all <= 1'b1;
    end else if (lamp_phase_reg != 3'h0) begin
      lamp_cnt_reg <= lamp_half_tick ? 32'h0 : lamp_cnt_reg + 32'h1;
      if (lamp_half_tick) begin
        lamp_phase_reg <= lamp_phase_reg - 3'h1;
        lamp_all <= lamp_phase_reg[0] && lamp_phase_reg != 3'h1; // Next phase even and not zero: lit.
      end
    end
  end

  // Auto-scale pacing; overloads caught between ticks are held so none slips by.
  wire settle_tick = settle_cnt_reg == 32'(SETTLE - 1);
  wire any_seen = |ovld_seen_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settle_cnt_reg <= 32'h0;
      ovld_seen_reg <= '0;
    end else begin
      settle_cnt_reg <= settle_tick ? 32'h0 : settle_cnt_reg + 32'h1;
      ovld_seen_reg <= (settle_tick ? '0 : ovld_seen_reg) | ovld_s2;
    end
  end

  // Gain stepping: down on overload, up after a clean window while on.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      auto_mode <= AUTO_OFF;
      for (int i = 0; i < NUM_CHANS; i++) begin
        gain_reg[i] <= '0;
      end
    end else if (set_auto) begin
      auto_mode <= cmd_param[1:0];
      if (cmd_param[1:0] == AUTO_NOW) begin
        for (int i = 0; i < NUM_CHANS; i++) begin
          gain_reg[i] <= GAIN_TOP;
        end
      end
    end else if (settle_tick && auto_mode != AUTO_OFF) begin
      for (int i = 0; i < NUM_CHANS; i++) begin
        if (ovld_seen_reg[i] && gain_reg[i] != '0) begin
          gain_reg[i] <= gain_reg[i] - GW'(1);
        end else if (!ovld_seen_reg[i] && auto_mode == AUTO_ON &&
                     gain_reg[i] != GAIN_TOP) begin
          gain_reg[i] <= gain_reg[i] + GW'(1);
        end
      end
      if (auto_mode == AUTO_NOW && !any_seen) begin
        auto_mode <= AUTO_OFF;
      end
    end
  end

  // Flatten the gain steps for the channel hardware.
  always_comb begin
    chan_gain_step = '0;
    for (int i = 0; i < NUM_CHANS; i++) begin
      chan_gain_step[3*i +: 3] = 3'(gain_reg[i]);
    end
  end
endmodule
`default_nettype wire

// ### test_remote_command_status_unit.sv
// Self-checking testbench for the remote command and status unit.
`timescale 1ns/100ps
`default_nettype none
module test_remote_command_status_unit
  import remote_cmd_pkg::*;
;
  logic clk, sys_rst, cmd_valid, cmd_query, cmd_ready, rsp_valid, lamp_all, job_req;
  logic job_done, slow, got, converter_fitted_flag, ignore_power_button_flag, dflt_ac_coupling;
  logic [7:0] cmd_unit, cmd_chan, rsp_unit, rsp_result, job_chan, job_result, res_sel, uid, to;
  logic [3:0] cmd_code, rsp_cmd, job_cmd;
  logic [15:0] cmd_param, job_param, dflt_gain_x10, dflt_sens_x10, dflt_fsci_x10;
  logic [15:0] dflt_fsco_x10, dflt_iexc_x10;
  logic [63:0] rsp_data, job_data;
  logic [2:0] load_fail, g;
  logic [3:0] short_pin, open_pin, ovld_pin;
  logic [1:0] dflt_input_mode, auto_mode;
  logic [11:0] chan_gain_step;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  remote_command_status_unit #(.NUM_CHANS(4), .LAMP_HALF(8), .SETTLE(16)) DUT (.clk, .sys_rst,
    .cmd_valid, .cmd_ready, .cmd_unit, .cmd_chan, .cmd_code, .cmd_query, .cmd_param,
    .rsp_valid, .rsp_unit, .rsp_cmd, .rsp_result, .rsp_data, .load_fail, .short_pin,
    .open_pin, .ovld_pin, .converter_fitted_flag, .ignore_power_button_flag, .lamp_all,
    .job_req, .job_cmd, .job_chan, .job_param, .job_done, .job_result, .job_data,
    .dflt_gain_x10, .dflt_sens_x10, .dflt_fsci_x10, .dflt_fsco_x10, .dflt_iexc_x10,
    .dflt_input_mode, .dflt_ac_coupling, .auto_mode, .chan_gain_step);
  job_model u_job (.clk, .sys_rst, .job_req, .res_sel, .slow, .job_done, .job_result,
    .job_data);

  // Free-running clock and a cycle ceiling that cuts a hang short.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("CHECK FAILED at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // One whole command and its answer; the host waits for each reply before the next.
  task automatic xfer(input logic [7:0] c, input logic [3:0] k, input logic q,
                      input logic [15:0] p, input logic [7:0] r);
    int i;
    logic [7:0] eu;
    eu = (k == CMD_SET_ID && !q && r == RES_OK) ? p[7:0] : uid;
    @(negedge clk);
    chk(cmd_ready === 1'b1, "port busy before a new command");
    {cmd_unit, cmd_chan, cmd_code, cmd_query, cmd_param} = {to, c, k, q, p};
    cmd_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    {cmd_unit, cmd_chan, cmd_code, cmd_query, cmd_param} = ~{to, c, k, q, p};
    got = 1'b0;
    for (i = 0; i < 60 && got == 1'b0; i++) begin
      if (rsp_valid === 1'b1) got = 1'b1;
      else @(negedge clk);
    end
    if (to != uid) chk(got === 1'b0, "foreign unit answered");
    else chk(got === 1'b1 && rsp_unit === eu && rsp_cmd === k && rsp_result === r, "answer");
    if (got === 1'b1) uid = eu;
    to = uid;
  endtask

  task automatic t_ident();
    xfer(8'h01, CMD_SET_ID, 1'b1, 16'h0000, RES_OK);
    chk(rsp_data[7:0] === 8'h01, "default id");
    to = 8'h02;
    xfer(8'h01, CMD_STATUS, 1'b1, 16'h0000, RES_OK);
    xfer(8'h01, CMD_SET_ID, 1'b0, 16'h0005, RES_OK);
    xfer(8'h01, CMD_SET_ID, 1'b1, 16'h0000, RES_OK);
    chk(rsp_data[7:0] === 8'h05, "id query");
    to = 8'h01;
    xfer(8'h01, CMD_STATUS, 1'b1, 16'h0000, RES_OK);
    xfer(8'h01, CMD_SET_ID, 1'b0, 16'h0000, RES_BAD_UNIT);
    xfer(8'h01, CMD_SET_ID, 1'b0, 16'h0064, RES_BAD_UNIT);
    xfer(8'h01, CMD_SET_ID, 1'b0, 16'h0001, RES_OK);
    $display("identifier test done");
  endtask

  task automatic t_status();
    {load_fail, short_pin, open_pin, ovld_pin} = {3'h5, 4'h1, 4'h8, 4'h4};
    repeat (4) @(negedge clk);
    xfer(8'h03, CMD_STATUS, 1'b1, 16'h0000, RES_OK);
    chk(rsp_data[39:0] === 40'h0503070605, "fault maps");
    {load_fail, short_pin, open_pin, ovld_pin} = '0;
    repeat (4) @(negedge clk);
    xfer(8'h09, CMD_STATUS, 1'b1, 16'h0000, RES_OK);
    chk(rsp_data[39:0] === 40'h0707070700, "clean maps");
    xfer(8'h01, CMD_STATUS, 1'b0, 16'h0000, RES_FUNC_FAIL);
    converter_fitted_flag = 1'b1;
    xfer(8'h01, CMD_CONFIG, 1'b1, 16'h0000, RES_OK);
    chk(rsp_data[39:0] === 40'h0104010002, "config bytes");
    {converter_fitted_flag, ignore_power_button_flag} = 2'h1;
    xfer(8'h01, CMD_CONFIG, 1'b1, 16'h0000, RES_OK);
    chk(rsp_data[7:0] === 8'h80, "power button flag");
    $display("status test done");
  endtask

  task automatic t_lamp();
    int n_hi;
    int n_rise;
    logic prev;
    xfer(8'h02, CMD_LAMP, 1'b0, 16'h1234, RES_OK);
    n_hi = (lamp_all === 1'b1) ? 1 : 0;
    n_rise = 0;
    prev = lamp_all;
    repeat (60) begin
      @(negedge clk);
      if (lamp_all === 1'b1) n_hi++;
      if (lamp_all === 1'b1 && prev === 1'b0) n_rise++;
      prev = lamp_all;
    end
    chk(n_hi == 24 && n_rise == 2, "three flashes");
    xfer(8'h02, CMD_LAMP, 1'b1, 16'h0000, RES_BAD_CMD);
    xfer(8'h02, CMD_RESTORE, 1'b1, 16'h0000, RES_BAD_CMD);
    xfer(8'h02, CMD_SAVE, 1'b1, 16'h0000, RES_BAD_CMD);
    xfer(8'h09, CMD_LAMP, 1'b0, 16'h0000, RES_BAD_CHAN);
    xfer(8'h01, 4'hF, 1'b1, 16'h0000, RES_BAD_CMD);
    $display("lamp test done");
  endtask

  task automatic t_jobs();
    int i;
    {res_sel, slow} = {RES_OK, 1'b1};
    xfer(8'h02, CMD_RESTORE, 1'b0, 16'h0000, RES_OK);
    chk({dflt_gain_x10, dflt_sens_x10, dflt_fsci_x10, dflt_fsco_x10, dflt_iexc_x10}
      === 80'h000A_0064_2710_0064_0028 && dflt_input_mode === 2'h0
      && dflt_ac_coupling === 1'b1, "defaults");
    chk(rsp_data === 64'h0123456789ABCDEF, "job data");
    xfer(8'h02, CMD_SAVE, 1'b0, 16'h0000, RES_OK);
    chk(job_cmd === CMD_SAVE, "save job");
    {res_sel, slow} = {8'h07, 1'b0};
    xfer(8'h02, CMD_SAVE, 1'b0, 16'h0000, RES_FUNC_FAIL);
    xfer(8'h01, CMD_BIAS, 1'b0, 16'h0000, RES_FUNC_FAIL);
    for (i = 0; i < 12; i++) begin
      res_sel = 8'hF5 - i[7:0];
      xfer(8'h01, CMD_CHANNEL, 1'b0, 16'h0000, res_sel);
    end
    res_sel = RES_NO_OPTION;
    xfer(8'h01, CMD_CHANNEL, 1'b0, 16'h0000, RES_NO_OPTION);
    res_sel = RES_BAD_PARAM;
    xfer(8'h01, CMD_CHANNEL, 1'b0, 16'h0000, RES_BAD_PARAM);
    res_sel = 8'hF6;
    xfer(8'h03, CMD_CHANNEL, 1'b0, 16'h00A5, RES_FUNC_FAIL);
    chk(job_cmd === CMD_CHANNEL && job_chan === 8'h03
      && job_param === 16'h00A5, "job fields");
    $display("job test done");
  endtask

  task automatic t_auto();
    xfer(8'h01, CMD_AUTO, 1'b0, 16'h0003, RES_BAD_PARAM);
    ovld_pin = 4'h2;
    repeat (3) @(negedge clk);
    xfer(8'h01, CMD_AUTO, 1'b0, 16'h0002, RES_OK);
    repeat (40) @(negedge clk);
    ovld_pin = 4'h0;
    repeat (80) @(negedge clk);
    chk(auto_mode === AUTO_OFF && chan_gain_step[2:0] === 3'h7
      && chan_gain_step[5:3] < 3'h7, "one-shot scaling");
    xfer(8'h01, CMD_AUTO, 1'b1, 16'h0000, RES_OK);
    chk(rsp_data[1:0] === AUTO_OFF, "auto query");
    g = chan_gain_step[5:3];
    xfer(8'h01, CMD_AUTO, 1'b0, 16'h0001, RES_OK);
    repeat (40) @(negedge clk);
    chk(auto_mode === AUTO_ON && chan_gain_step[5:3] > g, "gain climbs");
    xfer(8'h01, CMD_AUTO, 1'b0, 16'h0000, RES_OK);
    chk(auto_mode === AUTO_OFF, "auto off");
    $display("auto-scale test done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Reset for four cycles, then run the scenarios in turn.
  initial begin
    {clk, sys_rst, uid, to, res_sel, slow} = {1'b0, 1'b1, 8'h01, 8'h01, 8'h00, 1'b0};
    {cmd_valid, cmd_unit, cmd_chan, cmd_code, cmd_query, cmd_param} = '0;
    {load_fail, short_pin, open_pin, ovld_pin} = '0;
    {converter_fitted_flag, ignore_power_button_flag} = 2'h0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_ident();
    t_status();
    t_lamp();
    t_jobs();
    t_auto();
    tally_and_finish();
  end
endmodule
`default_nettype wire
